//--- core/plem_axil_slave.sv
// AXI4-Lite slave front end: one write and one read under way at a time.
// Assumes the parent decodes addresses and answers reads in the same cycle.
module plem_axil_slave (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read address and data
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  output logic wr_en,
  output logic [9:0] wr_idx,
  output logic [7:0] wr_data,
  output logic wr_lane0,
  input wire logic wr_err,
  output logic rd_en,
  output logic [9:0] rd_idx,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic aw_held_reg;
  logic w_held_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic ar_held_reg;
  logic [11:0] araddr_reg;

  // Write fires once both halves are held and no response is pending
  assign wr_en = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign wr_idx = awaddr_reg[11:2];
  assign wr_data = wdata_reg[7:0];
  assign wr_lane0 = wstrb_reg[0];
  assign rd_en = ar_held_reg && !s_axi_rvalid;
  assign rd_idx = araddr_reg[11:2];

  // Address and data taken in either order, each held until the write fires
  // Ready flops mirror the held flags so the ports leave straight from a flop
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      awaddr_reg <= 12'h000;
      wdata_reg <= plem_pkg::RESET_WORD;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held_reg)
      begin
        aw_held_reg <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_reg <= s_axi_awaddr;
      end
      else if (wr_en)
      begin
        aw_held_reg <= 1'b0;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && !w_held_reg)
      begin
        w_held_reg <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      else if (wr_en)
      begin
        w_held_reg <= 1'b0;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response held until the master takes it
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= plem_pkg::RESP_OKAY;
    end
    else if (wr_en)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_err ? plem_pkg::RESP_SLVERR : plem_pkg::RESP_OKAY;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read address latch, then data captured one cycle later
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      ar_held_reg <= 1'b0;
      s_axi_arready <= 1'b1;
      araddr_reg <= 12'h000;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= plem_pkg::RESET_WORD;
      s_axi_rresp <= plem_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && !ar_held_reg)
      begin
        ar_held_reg <= 1'b1;
        s_axi_arready <= 1'b0;
        araddr_reg <= s_axi_araddr;
      end
      else if (rd_en)
      begin
        ar_held_reg <= 1'b0;
        s_axi_arready <= 1'b1;
      end
      if (rd_en)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= rd_err ? plem_pkg::RESP_SLVERR : plem_pkg::RESP_OKAY;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

//--- core/plem_enable_bank.sv
// Top of the peripheral interrupt enable bank with its AXI4-Lite registers.
// Assumes peripheral request flags are level signals on the mclk domain.
module plem_enable_bank (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // AXI4-Lite write channels
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral request flags
  input wire logic timer2_reload_flag,
  input wire logic [3:0] timer2_cmp_flag,
  input wire logic serial_periph_flag,
  input wire logic two_wire_flag,
  input wire logic converter_flag,
  // Gated requests toward the core
  output logic timer2_reload_irq,
  output logic [3:0] timer2_cmp_irq,
  output logic serial_periph_irq,
  output logic two_wire_irq,
  output logic converter_irq,
  // Summary interrupt
  output logic irq
);
  logic [7:0] irq_enable_first_reg;
  logic [7:0] irq_enable_second_reg;
  logic global_irq_en_reg;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] mask_reg;
  logic [7:0] flag_prev_reg;
  logic [7:0] req_flag;
  logic [7:0] src_en;
  logic [7:0] req_taken;
  logic [7:0] flag_rise;
  logic [7:0] status_clr;
  logic wr_en;
  logic [9:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_lane0;
  logic wr_err;
  logic rd_en;
  logic [9:0] rd_idx;
  logic [31:0] rd_data;
  logic rd_err;
  logic timer2_reload_irq_en;
  logic [3:0] timer2_cmp_irq_en;
  logic serial_periph_irq_en;
  logic two_wire_irq_en;
  logic converter_irq_en;

  plem_axil_slave u_bus (
    .mclk(mclk),
    .srst(srst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_data(wr_data),
    .wr_lane0(wr_lane0),
    .wr_err(wr_err),
    .rd_en(rd_en),
    .rd_idx(rd_idx),
    .rd_data(rd_data),
    .rd_err(rd_err)
  );

  // Named enable fields out of the two enable registers
  assign timer2_reload_irq_en = irq_enable_first_reg[plem_pkg::BIT_RELOAD_EN];
  assign timer2_cmp_irq_en = irq_enable_first_reg[plem_pkg::BIT_CMP0_EN +: 4];
  assign serial_periph_irq_en = irq_enable_first_reg[plem_pkg::BIT_SERIAL_EN];
  assign two_wire_irq_en = irq_enable_first_reg[plem_pkg::BIT_TWO_WIRE_EN];
  assign converter_irq_en = irq_enable_second_reg[plem_pkg::BIT_CONVERTER_EN];

  // Source vectors in one order for flags, enables, status and mask
  assign req_flag = {timer2_reload_flag, converter_flag, timer2_cmp_flag,
                     serial_periph_flag, two_wire_flag};
  assign src_en[plem_pkg::SRC_RELOAD] = timer2_reload_irq_en;
  assign src_en[plem_pkg::SRC_CONVERTER] = converter_irq_en;
  assign src_en[plem_pkg::SRC_CMP0 +: 4] = timer2_cmp_irq_en;
  assign src_en[plem_pkg::SRC_SERIAL] = serial_periph_irq_en;
  assign src_en[plem_pkg::SRC_TWO_WIRE] = two_wire_irq_en;

  plem_irq_gate u_gate (
    .mclk(mclk),
    .srst(srst),
    .req_flag(req_flag),
    .src_en(src_en),
    .global_en(global_irq_en_reg),
    .req_taken(req_taken)
  );

  // Gated outputs come straight from the gate flip-flops
  assign timer2_reload_irq = req_taken[plem_pkg::SRC_RELOAD];
  assign converter_irq = req_taken[plem_pkg::SRC_CONVERTER];
  assign timer2_cmp_irq = req_taken[plem_pkg::SRC_CMP0 +: 4];
  assign serial_periph_irq = req_taken[plem_pkg::SRC_SERIAL];
  assign two_wire_irq = req_taken[plem_pkg::SRC_TWO_WIRE];

  // Write decode: only byte lane 0 carries register bits
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      irq_enable_first_reg <= plem_pkg::RESET_BYTE;
      irq_enable_second_reg <= plem_pkg::RESET_BYTE;
    end
    else if (wr_en && wr_lane0)
    begin
      if (wr_idx == plem_pkg::IDX_ENABLE_FIRST)
        irq_enable_first_reg <= wr_data & plem_pkg::FIRST_WRITE_MASK;
      if (wr_idx == plem_pkg::IDX_ENABLE_SECOND)
        irq_enable_second_reg <= wr_data & plem_pkg::SECOND_WRITE_MASK;
    end
  end

  // Global enable and event mask live in registers of their own
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      global_irq_en_reg <= 1'b0;
      mask_reg <= plem_pkg::RESET_BYTE;
    end
    else if (wr_en && wr_lane0)
    begin
      if (wr_idx == plem_pkg::IDX_CONTROL)
        global_irq_en_reg <= wr_data[plem_pkg::BIT_GLOBAL_EN];
      if (wr_idx == plem_pkg::IDX_MASK)
        mask_reg <= wr_data;
    end
  end

  // Writes to the status register are accepted but change nothing
  always_comb
  begin
    case (wr_idx)
      plem_pkg::IDX_ENABLE_FIRST,
      plem_pkg::IDX_ENABLE_SECOND,
      plem_pkg::IDX_CONTROL,
      plem_pkg::IDX_STATUS,
      plem_pkg::IDX_MASK: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  // Read mux; reserved bits and upper lanes read as zero
  always_comb
  begin
    rd_data = plem_pkg::RESET_WORD;
    rd_err = 1'b0;
    case (rd_idx)
      plem_pkg::IDX_ENABLE_FIRST: rd_data[7:0] = irq_enable_first_reg;
      plem_pkg::IDX_ENABLE_SECOND: rd_data[7:0] = irq_enable_second_reg;
      plem_pkg::IDX_CONTROL: rd_data[plem_pkg::BIT_GLOBAL_EN] = global_irq_en_reg;
      plem_pkg::IDX_STATUS: rd_data[7:0] = status_reg;
      plem_pkg::IDX_MASK: rd_data[7:0] = mask_reg;
      default: rd_err = 1'b1;
    endcase
  end

  // Events are flag rising edges, seen whatever the enables say
  assign flag_rise = req_flag & ~flag_prev_reg;
  assign status_clr = (rd_en && rd_idx == plem_pkg::IDX_STATUS) ? 8'hff : 8'h00;
  // A new event in the clearing read cycle survives the clear
  assign status_next = (status_reg & ~status_clr) | flag_rise;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      flag_prev_reg <= plem_pkg::RESET_BYTE;
      status_reg <= plem_pkg::RESET_BYTE;
    end
    else
    begin
      flag_prev_reg <= req_flag;
      status_reg <= status_next;
    end
  end

  // Summary line registered from the next status so it follows within a cycle
  always_ff @(posedge mclk)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |(status_next & mask_reg);
  end
endmodule

//--- core/plem_irq_gate.sv
// Per-source gate: request flag AND individual enable AND global enable.
// Assumes flags come from logic on mclk, so no synchroniser is needed.
module plem_irq_gate (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Gate inputs
  input wire logic [7:0] req_flag,
  input wire logic [7:0] src_en,
  input wire logic global_en,
  // Gated requests toward the core
  output logic [7:0] req_taken
);
  genvar i;
  // One registered gate per source; the flag itself is never altered
  generate
    for (i = 0; i < plem_pkg::NUM_SRC; i++)
    begin : g_src
      always_ff @(posedge mclk)
      begin
        if (srst)
          req_taken[i] <= 1'b0;
        else
          req_taken[i] <= req_flag[i] && src_en[i] && global_en;
      end
    end
  endgenerate
endmodule

//--- core/plem_pkg.sv
// Constants for the peripheral interrupt enable bank: map, fields, resets.
// Assumes a 32-bit AXI4-Lite slave with a 12-bit byte address.
package plem_pkg;
  // Register indexes as printed; byte address is four times the index
  localparam logic [9:0] IDX_ENABLE_FIRST = 10'h0b8;
  localparam logic [9:0] IDX_ENABLE_SECOND = 10'h09a;
  localparam logic [9:0] IDX_CONTROL = 10'h0c0;
  localparam logic [9:0] IDX_STATUS = 10'h0c1;
  localparam logic [9:0] IDX_MASK = 10'h0c2;
  localparam int ADDR_W = 12;
  localparam int NUM_SRC = 8;
  // Fields of the first enable register
  localparam int BIT_RELOAD_EN = 7;
  localparam int BIT_CMP0_EN = 2;
  localparam int BIT_SERIAL_EN = 1;
  localparam int BIT_TWO_WIRE_EN = 0;
  localparam logic [7:0] FIRST_WRITE_MASK = 8'hbf;
  // Fields of the second enable register
  localparam int BIT_CONVERTER_EN = 1;
  localparam logic [7:0] SECOND_WRITE_MASK = 8'h02;
  // Control register field
  localparam int BIT_GLOBAL_EN = 0;
  // Source order in request, status and mask vectors
  localparam int SRC_TWO_WIRE = 0;
  localparam int SRC_SERIAL = 1;
  localparam int SRC_CMP0 = 2;
  localparam int SRC_CONVERTER = 6;
  localparam int SRC_RELOAD = 7;
  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- verification/plem_enable_bank_sva.sv
// Concurrent checks on the enable bank's gated requests and bus answers.
// Assumes one mclk domain and the synchronous srst of the top module.
module plem_enable_bank_sva (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Flags and gated requests
  input wire logic timer2_reload_flag,
  input wire logic [3:0] timer2_cmp_flag,
  input wire logic serial_periph_flag,
  input wire logic two_wire_flag,
  input wire logic converter_flag,
  input wire logic timer2_reload_irq,
  input wire logic [3:0] timer2_cmp_irq,
  input wire logic serial_periph_irq,
  input wire logic two_wire_irq,
  input wire logic converter_irq,
  input wire logic irq,
  // Bus handshakes
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  // A gated request never appears without its flag one cycle earlier
  a_reload_gate: assert property (timer2_reload_irq |-> $past(timer2_reload_flag))
    else $error("reload request passed without flag");
  a_cmp_gate: assert property ((timer2_cmp_irq & ~$past(timer2_cmp_flag)) == 4'h0)
    else $error("compare request passed without flag");
  a_serial_gate: assert property (serial_periph_irq |-> $past(serial_periph_flag))
    else $error("serial request passed without flag");
  a_two_wire_gate: assert property (two_wire_irq |-> $past(two_wire_flag))
    else $error("two-wire request passed without flag");
  a_conv_gate: assert property (converter_irq |-> $past(converter_flag))
    else $error("converter request passed without flag");
  // Reset must silence every request, so no disable here
  a_reset_quiet: assert property (disable iff (1'h0) srst |=> !irq && !converter_irq &&
    !timer2_reload_irq && timer2_cmp_irq == 4'h0 && !serial_periph_irq && !two_wire_irq)
    else $error("request active after reset");
  // Answers stand until taken and come at the stated time
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
endmodule
bind plem_enable_bank plem_enable_bank_sva sva_u (.*);

//--- verification/plem_enable_bank_tb.sv
// Self-checking bench: bus tasks, flag model, queued read and write notes.
// Assumes the hand-over timing of the bank and its byte-lane-0 registers.
module plem_enable_bank_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] A1 = {plem_pkg::IDX_ENABLE_FIRST, 2'h0};
  localparam logic [11:0] A2 = {plem_pkg::IDX_ENABLE_SECOND, 2'h0};
  localparam logic [11:0] AC = {plem_pkg::IDX_CONTROL, 2'h0};
  localparam logic [11:0] AS = {plem_pkg::IDX_STATUS, 2'h0};
  localparam logic [11:0] AM = {plem_pkg::IDX_MASK, 2'h0};
  logic mclk = 1'h0;
  logic srst = 1'h1;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic timer2_reload_irq, serial_periph_irq, two_wire_irq, converter_irq, irq;
  logic [3:0] timer2_cmp_irq;
  logic [7:0] flag_cmd = 8'h00, fv, st = 8'h00;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int n_fail = 0, cmp_count = 0, cyc = 0;
  plem_flag_src fsrc_u (.mclk(mclk), .srst(srst), .flag_cmd(flag_cmd), .flag_vec(fv));
  plem_enable_bank dut_u (.*, .timer2_reload_flag(fv[7]), .timer2_cmp_flag(fv[5:2]),
    .serial_periph_flag(fv[1]), .two_wire_flag(fv[0]), .converter_flag(fv[6]));
  always #2.5 mclk = ~mclk;
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Hang guard: a run far beyond the planned length counts as a mismatch
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end
  // Results are taken against the oldest note as they appear
  always @(posedge mclk)
  begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
      chk(34'(s_axi_bresp), 34'(bq.pop_front()));
  end
  // Write: both halves offered together, each released once taken
  // A random late bready lets the response wait, so its hold is exercised
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    int w;
    w = int'($urandom() % 4);
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= ($urandom() & 32'hffff_ff00) | 32'(d);
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    bq.push_back(r);
    do
    begin
      @(posedge mclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
      if (w > 0)
        w--;
      else if (!s_axi_bready)
        s_axi_bready <= 1'h1;
    end
    while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'h0;
  endtask
  // Same for reads: rready may come late, read data must stand meanwhile
  task automatic rd(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
    int w;
    w = int'($urandom() % 4);
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    rq.push_back({r, 24'h00_0000, d});
    do
    begin
      @(posedge mclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
      if (w > 0)
        w--;
      else if (!s_axi_rready)
        s_axi_rready <= 1'h1;
    end
    while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'h0;
  endtask
  // Sticky status expectation tracks every rising flag
  task automatic flags(input logic [7:0] f);
    @(posedge mclk);
    st = st | (f & ~flag_cmd);
    flag_cmd <= f;
    repeat (3) @(posedge mclk);
  endtask
  task automatic gate(input logic [7:0] e, input logic g, input logic [7:0] f);
    wr(A1, e, 2'h0);
    wr(A2, {6'h00, e[6], 1'h0}, 2'h0);
    wr(AC, {7'h00, g}, 2'h0);
    rd(A1, e & 8'hbf, 2'h0);
    flags(f);
    chk(34'({timer2_reload_irq, converter_irq, timer2_cmp_irq, serial_periph_irq,
      two_wire_irq}), 34'(f & e & {8{g}}));
  endtask
  initial
  begin
    void'($urandom(32'h0000_c14a));
    repeat (12) @(posedge mclk);
    srst <= 1'h0;
    // Reset values, reserved bits and an unmapped place
    rd(A1, 8'h00, 2'h0);
    rd(A2, 8'h00, 2'h0);
    wr(A1, 8'hff, 2'h0);
    rd(A1, 8'hbf, 2'h0);
    // A write without byte lane 0 leaves the register as it was
    s_axi_wstrb <= 4'he;
    wr(A1, 8'h00, 2'h0);
    s_axi_wstrb <= 4'hf;
    rd(A1, 8'hbf, 2'h0);
    wr(A2, 8'hff, 2'h0);
    rd(A2, 8'h02, 2'h0);
    wr(12'hffc, 8'hff, 2'h2);
    rd(12'hffc, 8'h00, 2'h2);
    // Each source alone, then random mixes, then global enable off
    for (int i = 0; i < 8; i++)
      gate(8'h01 << i, 1'h1, 8'hff);
    for (int i = 0; i < 12; i++)
      gate(8'($urandom()), 1'($urandom()), 8'($urandom()));
    gate(8'hff, 1'h0, 8'hff);
    // Events stick whatever the enables; a masked-in event drives irq until read
    gate(8'h00, 1'h0, 8'h00);
    rd(AS, st, 2'h0);
    st = 8'h00;
    wr(AM, 8'h04, 2'h0);
    flags(8'h44);
    chk(34'(irq), 34'h1);
    rd(AS, st, 2'h0);
    chk(34'(irq), 34'h0);
    tally_and_finish();
  end
endmodule

//--- verification/plem_flag_src.sv
// Model of the peripheral request sources that feed the enable bank.
// Assumes the bench commands flag levels on mclk, in status vector order.
module plem_flag_src (
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Commanded levels in, request flags out
  input wire logic [7:0] flag_cmd,
  output logic [7:0] flag_vec
);
  timeunit 1ns;
  timeprecision 1ps;
  // Flags are levels held until the source itself drops them
  always_ff @(posedge mclk)
  begin
    if (srst)
      flag_vec <= 8'h00;
    else
      flag_vec <= flag_cmd;
  end
endmodule
